// File: dv/flow_totalizer_batch_bench.sv
// self-checking bench for the flow totalizer with batch dispenser
`default_nettype none
module flow_totalizer_batch_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import ftb_pkg::*;
   // ==========================================================
   // stimulus and observed signals
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h0;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
   logic wb_ack_o, rkey, tkey, skey, pwr;
   logic meas_tick_i = 1'b0;
   logic [7:0] flow_sample_i = 8'h0;
   logic [15:0] flow_target_key_i = 16'h0;
   logic flow_en_o, disp_time_o, frac_digits_o, overflow_o, batch_done_o;
   logic [3:0] press = 4'h0;  // key requests to the panel model
   logic [71:0] exp_q[$];     // {addr, mask, value} per pending read
   logic [31:0] lfsr = 32'h65F7546B;
   logic [1:0] modes [3] = '{FTB_OVF_SAT, FTB_OVF_WRAP, FTB_OVF_NOTE};
   int n_mismatch = 0;
   int check_count = 0;
   int sum = 0;
   // two digits and a 10-cycle second keep overflow and time short
   ftb_top #(.DIGITS(2), .SEC_CYCLES(10)) dut (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .reset_key_i(rkey),
      .toggle_key_i(tkey), .set_key_i(skey), .power_lost_i(pwr),
      .meas_tick_i(meas_tick_i), .flow_sample_i(flow_sample_i),
      .flow_target_key_i(flow_target_key_i), .flow_en_o(flow_en_o),
      .disp_time_o(disp_time_o), .frac_digits_o(frac_digits_o),
      .overflow_o(overflow_o), .batch_done_o(batch_done_o));
   ftb_panel panel (.clk_i(clk_i), .press_i(press), .reset_key_o(rkey),
      .toggle_key_o(tkey), .set_key_o(skey), .power_lost_o(pwr));
   // ==========================================================
   // clock and helpers
   initial begin
      forever #5 clk_i = ~clk_i;
   end
   task automatic cmp(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %s exp %h got %h", nm, e, g);
      end
   endtask : cmp
   // next state of the stimulus shift register
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next
   task automatic wrap_up;
      if (n_mismatch == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : wrap_up
   // one classic cycle, held until ack is sampled
   task automatic bus(input logic we, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= s;
      // only the watchdog ends a wait for ack
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'hF);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
      exp_q.push_back({a, m, e});
      bus(1'b0, a, 32'h0, 4'hF);
   endtask : rd
   // one tick, then room for one unit per clock to drain
   task automatic tick(input logic [7:0] v);
      @(posedge clk_i);
      meas_tick_i <= 1'b1;
      flow_sample_i <= v;
      @(posedge clk_i);
      meas_tick_i <= 1'b0;
      repeat (int'(v) + 6) @(posedge clk_i);
   endtask : tick
   task automatic key(input int k);
      @(posedge clk_i);
      press <= 4'h1 << k;
      @(posedge clk_i);
      press <= 4'h0;
      repeat (14) @(posedge clk_i);
   endtask : key
   // read monitor: oldest note against each read answer
   always @(posedge clk_i) begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() != 0) begin
         cmp($sformatf("reg %h", exp_q[0][71:64]), exp_q[0][31:0],
             wb_dat_o & exp_q[0][63:32]);
         void'(exp_q.pop_front());
      end
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      n_mismatch++;
      wrap_up();
   end
   // ==========================================================
   // main sequence
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(FTB_OFS_STAT, '1, 32'h0);
      rd(FTB_OFS_BATCH, '1, 32'h0);
      rd(8'h40, '1, 32'h0);
      for (int i = 0; i < 3; i++) begin
         lfsr = lfsr_next(lfsr);
         sum += int'(lfsr[3:0]) + 1;
         tick(8'(int'(lfsr[3:0]) + 1));
      end
      rd(FTB_OFS_TOTAL, '1, 32'(((sum / 10) << 4) + sum % 10));
      bus(1'b1, FTB_OFS_CTRL, 32'h4, 4'h3);
      rd(FTB_OFS_CTRL, 32'h7, 32'h0);
      wr(FTB_OFS_CTRL, 32'h4);
      #1 cmp("frac_digits_o", 32'h1, {31'h0, frac_digits_o});
      for (int i = 0; i < 3; i++) begin
         wr(FTB_OFS_CMD, 32'h1);
         wr(FTB_OFS_CTRL, {30'h0, modes[i]});
         tick(8'h69);
         rd(FTB_OFS_TOTAL, '1, i == 0 ? 32'h99 : 32'h5);
         #1 cmp("overflow_o", {31'h0, i == 2}, {31'h0, overflow_o});
      end
      wr(FTB_OFS_CMD, 32'h1);
      rd(FTB_OFS_STAT, 32'h1, 32'h0);
      flow_target_key_i <= lfsr[15:0] | 16'h1;
      wr(FTB_OFS_BATCH, 32'h3);
      rd(FTB_OFS_STAT, 32'hE, 32'h6);
      tick(8'h2);
      rd(FTB_OFS_REMAIN, '1, 32'h1);
      wr(FTB_OFS_STAGE, 32'h7);
      rd(FTB_OFS_REMAIN, '1, 32'h1);
      tick(8'h4);
      rd(FTB_OFS_STAT, 32'hE, 32'h8);
      #1 cmp("batch_done_o", 32'h1, {31'h0, batch_done_o});
      rd(FTB_OFS_REMAIN, '1, 32'h0);
      key(0);
      rd(FTB_OFS_TOTAL, '1, 32'h0);
      rd(FTB_OFS_STAT, 32'hE, 32'h6);
      key(2);
      rd(FTB_OFS_REMAIN, '1, 32'h7);
      flow_target_key_i <= 16'h0;
      key(2);
      #1 cmp("flow_en_o", 32'h0, {31'h0, flow_en_o});
      tick(8'h2);
      key(3);
      rd(FTB_OFS_TOTAL, '1, 32'h0);
      rd(FTB_OFS_BATCH, '1, 32'h7);
      wr(FTB_OFS_CMD, 32'h1);
      tick(8'h3);
      tick(8'h2);
      rd(FTB_OFS_PEAK, '1, 32'h3);
      flow_target_key_i <= 16'h5;
      wr(FTB_OFS_BATCH, 32'h0);
      rd(FTB_OFS_STAT, 32'hE, 32'h2);
      tick(8'h4);
      rd(FTB_OFS_TOTAL, '1, 32'h9);
      // host commit of the staged 7 while total is already past it
      rd(FTB_OFS_STAGE, '1, 32'h7);
      wr(FTB_OFS_CMD, 32'h2);
      rd(FTB_OFS_STAT, 32'hE, 32'h8);
      key(1);
      rd(FTB_OFS_STAT, 32'h10, 32'h10);
      key(1);
      #1 cmp("disp_time_o", 32'h0, {31'h0, disp_time_o});
      wr(FTB_OFS_CMD, 32'h4);
      rd(FTB_OFS_STAT, 32'h10, 32'h10);
      wr(FTB_OFS_CMD, 32'h1);
      rd(FTB_OFS_TIME, 32'hFFFFFFC0, 32'h0);
      repeat (700) @(posedge clk_i);
      rd(FTB_OFS_TIME, 32'hFFFFFFC0, 32'h40);
      wrap_up();
   end
endmodule : flow_totalizer_batch_bench
`default_nettype wire

// File: dv/ftb_panel.sv
// bench side: front panel key and power model for the totalizer
`default_nettype none
module ftb_panel (
   input wire logic clk_i,         // core clock
   input wire logic [3:0] press_i, // 0 reset, 1 toggle, 2 set, 3 power
   output logic reset_key_o,       // reset key pin
   output logic toggle_key_o,      // total/time key pin
   output logic set_key_o,         // set key pin
   output logic power_lost_o       // power-loss level
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // key hold
   logic [3:0] cnt_r [4] = '{default: 4'h0}; // hold cycles left per key
   // held 8 cycles so the two-flop synchroniser cannot miss a press
   always_ff @(posedge clk_i) begin
      for (int k = 0; k < 4; k++) begin
         if (press_i[k]) begin
            cnt_r[k] <= 4'h8;
         end else if (cnt_r[k] != 4'h0) begin
            cnt_r[k] <= cnt_r[k] - 4'h1;
         end
      end
   end
   assign reset_key_o = cnt_r[0] != 4'h0;
   assign toggle_key_o = cnt_r[1] != 4'h0;
   assign set_key_o = cnt_r[2] != 4'h0;
   assign power_lost_o = cnt_r[3] != 4'h0;
endmodule : ftb_panel
`default_nettype wire

// File: rtl/ftb_pkg.sv
// shared constants for the flow totalizer with batch dispenser
`default_nettype none
package ftb_pkg;
   // ==========================================================
   // bus register byte offsets
   localparam logic [7:0] FTB_OFS_CTRL = 8'h00;   // overflow mode, resolution
   localparam logic [7:0] FTB_OFS_CMD = 8'h04;    // write-only command strobes
   localparam logic [7:0] FTB_OFS_STAT = 8'h08;   // block state
   localparam logic [7:0] FTB_OFS_TOTAL = 8'h0C;  // bcd total
   localparam logic [7:0] FTB_OFS_TIME = 8'h10;   // hours, minutes, seconds
   localparam logic [7:0] FTB_OFS_PEAK = 8'h14;   // peak flow sample
   localparam logic [7:0] FTB_OFS_REMAIN = 8'h18; // bcd remaining quantity
   localparam logic [7:0] FTB_OFS_STAGE = 8'h1C;  // panel entry, set key commits
   localparam logic [7:0] FTB_OFS_BATCH = 8'h5C;  // serial register 92
   // ==========================================================
   // field positions
   localparam int FTB_CMD_CLEAR = 0;     // serial clear command
   localparam int FTB_CMD_COMMIT = 1;    // commit staged target
   localparam int FTB_CMD_TOGGLE = 2;    // swap primary display
   localparam int FTB_CTRL_FRAC = 2;     // two fractional digits when set
   localparam int FTB_TIME_MIN_LSB = 6;  // minutes field
   localparam int FTB_TIME_HRS_LSB = 12; // hours field
   // ==========================================================
   // overflow policies
   localparam logic [1:0] FTB_OVF_SAT = 2'h0;   // stop at maximum
   localparam logic [1:0] FTB_OVF_WRAP = 2'h1;  // silent wrap
   localparam logic [1:0] FTB_OVF_NOTE = 2'h2;  // wrap and flag
   localparam logic [1:0] FTB_CTRL_RST = 2'h0;  // reset policy
   // ==========================================================
   // digit and time limits
   localparam logic [3:0] FTB_DIG_MAX = 4'h9;
   localparam logic [3:0] FTB_DIG_TEN = 4'hA;
   localparam logic [13:0] FTB_HRS_MAX = 14'h270F; // 9999 hours
   localparam logic [5:0] FTB_MS_MAX = 6'h3B;      // 59 min or s
   // ==========================================================
   // timing: one second at the core clock
   localparam int FTB_CLK_NS = 10;          // 100 MHz period
   localparam int FTB_SEC_NS = 1000000000;  // one second in ns
   localparam int FTB_SEC_CYC = FTB_SEC_NS / FTB_CLK_NS;
   // batch states
   typedef enum logic [1:0] {
      FTB_B_IDLE = 2'b00,  // batch mode off
      FTB_B_RUN = 2'b01,   // dispensing toward target
      FTB_B_DONE = 2'b10   // target reached, flow stopped
   } ftb_batch_e;
endpackage : ftb_pkg
`default_nettype wire

// File: rtl/ftb_top.sv
// flow totalizer, elapsed timer, peak hold and batch dispenser
`default_nettype none
module ftb_top #(
   parameter int DIGITS = 8,                   // bcd digits of the total
   parameter int SAMPLE_W = 8,                 // flow sample width
   parameter int SETPOINT_W = 16,              // setpoint width
   parameter int SEC_CYCLES = ftb_pkg::FTB_SEC_CYC // cycles per second
) (
   input wire logic clk_i,                     // core clock
   input wire logic rst_i,                     // sync reset, high
   input wire logic wb_cyc_i,                  // wishbone cycle
   input wire logic wb_stb_i,                  // wishbone strobe
   input wire logic wb_we_i,                   // write enable
   input wire logic [7:0] wb_adr_i,            // byte address
   input wire logic [3:0] wb_sel_i,            // byte lanes
   input wire logic [31:0] wb_dat_i,           // write data
   output logic [31:0] wb_dat_o,               // read data
   output logic wb_ack_o,                      // one-cycle ack
   input wire logic reset_key_i,               // panel reset key, pin
   input wire logic toggle_key_i,              // panel total/time key, pin
   input wire logic set_key_i,                 // panel set key, pin
   input wire logic power_lost_i,              // power-loss level, pin
   input wire logic meas_tick_i,               // measurement tick pulse
   input wire logic [SAMPLE_W-1:0] flow_sample_i, // scaled flow per tick
   input wire logic [SETPOINT_W-1:0] flow_target_key_i, // active setpoint
   output logic flow_en_o,                     // valve may open
   output logic disp_time_o,                   // primary shows time
   output logic frac_digits_o,                 // two fractional digits
   output logic overflow_o,                    // overflow error shown
   output logic batch_done_o                   // batch complete
);
   import ftb_pkg::*;

   localparam int TW = 4 * DIGITS;             // total width
   localparam int PW = SAMPLE_W + 8;           // pending step width
   localparam int DW = $clog2(SEC_CYCLES);     // divider width

   // ==========================================================
   // elaboration checks
   if (DIGITS < 1 || DIGITS > 8) begin : g_chk_dig
      $error("DIGITS must be 1..8 to fit a bus word");
   end
   if (SEC_CYCLES < 2) begin : g_chk_sec
      $error("SEC_CYCLES must be at least 2");
   end
   if (SAMPLE_W < 1 || SAMPLE_W > 24 || SETPOINT_W < 1) begin : g_chk_w
      $error("sample or setpoint width out of range");
   end

   // ==========================================================
   // state record
   typedef struct packed {
      logic [3:0] pin_s1;          // first sync stage, pins
      logic [3:0] pin_s2;          // second sync stage
      logic [3:0] pin_s3;          // edge history
      logic ack;                   // bus ack
      logic [31:0] rdat;           // bus read data
      logic [1:0] ovf_mode;        // overflow policy
      logic frac;                  // resolution choice
      logic [TW-1:0] total;        // bcd total
      logic [PW-1:0] pend;         // units still to count
      logic ovf;                   // sticky overflow error
      logic [DW-1:0] div;          // second divider
      logic [13:0] hrs;            // elapsed hours
      logic [5:0] mins;            // elapsed minutes
      logic [5:0] secs;            // elapsed seconds
      logic [SAMPLE_W-1:0] peak;   // highest sample
      logic [TW-1:0] stage;        // panel entry, not yet live
      logic [TW-1:0] target;       // live batch target
      ftb_batch_e bst;             // batch state
      logic done;                  // batch complete flag
      logic flow_en;               // valve enable
      logic disp;                  // primary display select
      logic [TW-1:0] remain;       // remaining quantity
   } ftb_state_s;

   ftb_state_s q_r;                // registered state
   ftb_state_s q_nxt;              // next state

   // ==========================================================
   // per-digit bcd increment and remaining subtraction
   logic [DIGITS:0] inc_c;         // increment carry chain
   logic [DIGITS:0] sub_b;         // subtraction borrow chain
   logic [TW-1:0] inc_w;           // total plus one unit
   logic [TW-1:0] rem_w;           // target minus total
   assign inc_c[0] = 1'b1;
   assign sub_b[0] = 1'b0;
   for (genvar i = 0; i < DIGITS; i++) begin : g_dig
      logic [3:0] d;               // total digit
      logic [4:0] df;              // signed digit difference
      assign d = q_r.total[4*i +: 4];
      // a digit at nine with carry in rolls to zero
      assign inc_c[i+1] = inc_c[i] & (d == FTB_DIG_MAX);
      assign inc_w[4*i +: 4] = (inc_c[i] & (d == FTB_DIG_MAX)) ? 4'h0
                               : d + {3'h0, inc_c[i]};
      assign df = {1'b0, q_r.target[4*i +: 4]} - {1'b0, d}
                  - {4'h0, sub_b[i]};
      assign sub_b[i+1] = df[4];
      // a negative digit gets ten added back
      assign rem_w[4*i +: 4] = df[4] ? df[3:0] + FTB_DIG_TEN : df[3:0];
   end

   // ==========================================================
   // decoded events
   logic all9;                     // total at maximum count
   logic step;                     // count one unit this cycle
   logic clr;                      // any clear source
   logic commit;                   // target commit this cycle
   logic [TW-1:0] commit_val;      // value being committed
   logic sec_tick;                 // one-second enable
   logic reached;                  // total at or past target
   logic wb_req;                   // new bus request
   logic wb_wr;                    // new bus write
   logic key_reset;                // reset key press edge
   logic key_toggle;               // toggle key press edge
   logic key_set;                  // set key press edge
   logic time_max;                 // timer at its ceiling

   assign all9 = inc_c[DIGITS];
   assign step = (q_r.pend != '0);
   assign wb_req = wb_cyc_i & wb_stb_i & ~q_r.ack;
   assign wb_wr = wb_req & wb_we_i & (&wb_sel_i);
   assign key_reset = q_r.pin_s2[0] & ~q_r.pin_s3[0];
   assign key_toggle = q_r.pin_s2[1] & ~q_r.pin_s3[1];
   assign key_set = q_r.pin_s2[2] & ~q_r.pin_s3[2];
   // key, serial and power loss all clear the counts
   assign clr = key_reset | q_r.pin_s2[3]
                | (wb_wr & (wb_adr_i == FTB_OFS_CMD)
                   & wb_dat_i[FTB_CMD_CLEAR]);
   // a host write to the batch register commits like the set key
   assign commit = key_set | (wb_wr & (wb_adr_i == FTB_OFS_BATCH))
                   | (wb_wr & (wb_adr_i == FTB_OFS_CMD)
                      & wb_dat_i[FTB_CMD_COMMIT]);
   assign commit_val = (wb_wr & (wb_adr_i == FTB_OFS_BATCH))
                       ? wb_dat_i[TW-1:0] : q_r.stage;
   assign sec_tick = (q_r.div == DW'(SEC_CYCLES - 1));
   assign reached = (q_r.total >= q_r.target);
   assign time_max = (q_r.hrs == FTB_HRS_MAX) & (q_r.mins == FTB_MS_MAX)
                     & (q_r.secs == FTB_MS_MAX);

   // ==========================================================
   // next-state logic
   always_comb begin
      q_nxt = q_r;
      // pins pass two flops before use; s1 feeds only s2
      q_nxt.pin_s1 = {power_lost_i, set_key_i, toggle_key_i, reset_key_i};
      q_nxt.pin_s2 = q_r.pin_s1;
      q_nxt.pin_s3 = q_r.pin_s2;

      // bus slave: ack one cycle after request, then drop
      q_nxt.ack = wb_req;
      q_nxt.rdat = 32'h0;
      if (wb_req && !wb_we_i) begin
         case (wb_adr_i)
            FTB_OFS_CTRL: q_nxt.rdat = 32'({q_r.frac, q_r.ovf_mode});
            FTB_OFS_STAT: q_nxt.rdat = 32'({q_r.disp, q_r.done,
                                            q_r.bst == FTB_B_RUN,
                                            q_r.flow_en, q_r.ovf});
            FTB_OFS_TOTAL: q_nxt.rdat = 32'(q_r.total);
            FTB_OFS_TIME: q_nxt.rdat = 32'({q_r.hrs, q_r.mins, q_r.secs});
            FTB_OFS_PEAK: q_nxt.rdat = 32'(q_r.peak);
            FTB_OFS_REMAIN: q_nxt.rdat = 32'(q_r.remain);
            FTB_OFS_STAGE: q_nxt.rdat = 32'(q_r.stage);
            FTB_OFS_BATCH: q_nxt.rdat = 32'(q_r.target);
            default: q_nxt.rdat = 32'h0; // unmapped reads as zero
         endcase
      end
      if (wb_wr && wb_adr_i == FTB_OFS_CTRL) begin
         q_nxt.ovf_mode = wb_dat_i[1:0];
         q_nxt.frac = wb_dat_i[FTB_CTRL_FRAC];
      end
      // staged entry has no effect until committed
      if (wb_wr && wb_adr_i == FTB_OFS_STAGE) begin
         q_nxt.stage = wb_dat_i[TW-1:0];
      end

      // display swap on key or host command
      if (key_toggle || (wb_wr && wb_adr_i == FTB_OFS_CMD
                         && wb_dat_i[FTB_CMD_TOGGLE])) begin
         q_nxt.disp = ~q_r.disp;
      end

      // one-second divider runs free
      q_nxt.div = sec_tick ? '0 : q_r.div + DW'(1);

      if (clr) begin
         // counts restart; target is kept
         q_nxt.total = '0;
         q_nxt.ovf = 1'b0;
         q_nxt.hrs = '0;
         q_nxt.mins = '0;
         q_nxt.secs = '0;
         q_nxt.peak = '0;
         // a tick in the clear cycle counts after the clear
         q_nxt.pend = meas_tick_i ? PW'(flow_sample_i) : '0;
         if (meas_tick_i) begin
            q_nxt.peak = flow_sample_i;
         end
      end else begin
         // sample joins pending units, one unit counted per cycle
         // limitation: samples must not outpace the clock
         if (meas_tick_i) begin
            q_nxt.pend = (q_r.pend > ~PW'(flow_sample_i)) ? '1
                         : q_r.pend + PW'(flow_sample_i)
                           - PW'(step);
         end else if (step) begin
            q_nxt.pend = q_r.pend - PW'(1);
         end
         if (step) begin
            if (!all9) begin
               q_nxt.total = inc_w;
            end else if (q_r.ovf_mode == FTB_OVF_SAT) begin
               q_nxt.pend = '0; // hold at maximum
            end else begin
               q_nxt.total = '0; // roll over
               if (q_r.ovf_mode == FTB_OVF_NOTE) begin
                  q_nxt.ovf = 1'b1; // flag and go on
               end
            end
         end
         // peak holds the largest sample since clear
         if (meas_tick_i && flow_sample_i > q_r.peak) begin
            q_nxt.peak = flow_sample_i;
         end
         // hms timer, stuck at its ceiling
         if (sec_tick && !time_max) begin
            if (q_r.secs != FTB_MS_MAX) begin
               q_nxt.secs = q_r.secs + 6'h1;
            end else begin
               q_nxt.secs = '0;
               if (q_r.mins != FTB_MS_MAX) begin
                  q_nxt.mins = q_r.mins + 6'h1;
               end else begin
                  q_nxt.mins = '0;
                  q_nxt.hrs = q_r.hrs + 14'h1;
               end
            end
         end
      end

      // batch sequencing
      case (q_r.bst)
         FTB_B_IDLE: begin
            q_nxt.done = 1'b0;
         end
         FTB_B_RUN: begin
            // target reached: stop and report done
            if (reached && !clr) begin
               q_nxt.bst = FTB_B_DONE;
               q_nxt.done = 1'b1;
            end
         end
         FTB_B_DONE: begin
            // a clear restarts the same size batch
            if (clr) begin
               q_nxt.bst = FTB_B_RUN;
               q_nxt.done = 1'b0;
            end
         end
         default: begin
            q_nxt.bst = FTB_B_IDLE;
            q_nxt.done = 1'b0;
         end
      endcase
      if (commit) begin
         q_nxt.target = commit_val;
         // zero turns batch mode off, nonzero arms it
         q_nxt.bst = (commit_val == '0) ? FTB_B_IDLE : FTB_B_RUN;
         q_nxt.done = 1'b0;
      end

      // remaining quantity, zero once target met
      q_nxt.remain = reached ? '0 : rem_w;
      // valve opens on nonzero setpoint unless batch done
      q_nxt.flow_en = (flow_target_key_i != '0)
                      && (q_nxt.bst != FTB_B_DONE);
   end

   // ==========================================================
   // state register; target resets once, power loss leaves it alone
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q_r <= '0;
         q_r.ovf_mode <= FTB_CTRL_RST;
         q_r.bst <= FTB_B_IDLE;
      end else begin
         q_r <= q_nxt;
      end
   end

   // outputs straight from flops
   assign wb_dat_o = q_r.rdat;
   assign wb_ack_o = q_r.ack;
   assign flow_en_o = q_r.flow_en;
   assign disp_time_o = q_r.disp;
   assign frac_digits_o = q_r.frac;
   assign overflow_o = q_r.ovf;
   assign batch_done_o = q_r.done;

   // ==========================================================
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_wrap_step;
      step && all9 && !clr;
   endsequence
   sequence s_target_hit;
      q_r.bst == FTB_B_RUN && reached && !clr && !commit;
   endsequence

   chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   chk_sat_hold: assert property (
      s_wrap_step and (q_r.ovf_mode == FTB_OVF_SAT)
      |=> q_r.total == $past(q_r.total) && q_r.pend == '0)
      else $error("saturated total moved");
   chk_wrap_zero: assert property (
      s_wrap_step and (q_r.ovf_mode == FTB_OVF_WRAP) and !q_r.ovf
      |=> q_r.total == '0 && !overflow_o)
      else $error("silent wrap wrong");
   chk_wrap_flag: assert property (
      s_wrap_step and (q_r.ovf_mode == FTB_OVF_NOTE)
      |=> q_r.total == '0 && overflow_o)
      else $error("notified wrap missing flag");
   chk_time_clear: assert property (
      clr |=> q_r.hrs == '0 && q_r.mins == '0 && q_r.secs == '0
              && q_r.total == '0)
      else $error("clear did not zero counts");
   chk_time_sat: assert property (
      time_max && !clr |=> time_max)
      else $error("timer passed its ceiling");
   chk_toggle_disp: assert property (
      key_toggle && !(wb_wr && wb_adr_i == FTB_OFS_CMD)
      |=> disp_time_o != $past(disp_time_o))
      else $error("toggle key ignored");
   chk_done_stop: assert property (
      s_target_hit |=> batch_done_o && !flow_en_o
                       && q_r.remain == '0)
      else $error("batch did not stop at target");
   chk_rerun_batch: assert property (
      q_r.bst == FTB_B_DONE && clr && !commit
      |=> q_r.bst == FTB_B_RUN ##1 !batch_done_o)
      else $error("reset did not restart batch");
   chk_zero_setpoint: assert property (
      flow_target_key_i == '0 |=> !flow_en_o)
      else $error("flow enabled without setpoint");
   chk_zero_target: assert property (
      commit && commit_val == '0 |=> q_r.bst == FTB_B_IDLE
                                     && !batch_done_o)
      else $error("zero target left batch armed");
   chk_peak_hold: assert property (
      meas_tick_i && !clr |=> q_r.peak >= $past(flow_sample_i))
      else $error("peak below recent sample");

endmodule : ftb_top
`default_nettype wire
